// ### hw/aa_regs.vh
// Constants for the amplifier page-zero control registers.
// Assumes inclusion by bare name from the design files.
`ifndef AA_REGS_VH
`define AA_REGS_VH

// ********************************
// Register offsets
// ********************************
`define AA_OFS_MUTE        8'h03
`define AA_OFS_PLL         8'h04
`define AA_OFS_FILT        8'h07
`define AA_OFS_PIN_DIR     8'h08
`define AA_OFS_SER_IF      8'h09

// ********************************
// Reset values
// ********************************
`define AA_RST_MUTE        8'h00
`define AA_RST_PLL         8'h01
`define AA_RST_FILT        8'h00
`define AA_RST_PIN_DIR     8'h00
`define AA_RST_SER_IF      8'h00

// ********************************
// Writable bit masks
// ********************************
`define AA_WMASK_MUTE      8'h11
`define AA_WMASK_PLL       8'h01
`define AA_WMASK_FILT      8'h11
`define AA_WMASK_PIN_DIR   8'h2c
`define AA_WMASK_SER_IF    8'h31

// ********************************
// Field positions
// ********************************
`define AA_BIT_MUTE_B      4
`define AA_BIT_MUTE_A      0
`define AA_BIT_PLL_LOCK_N  4
`define AA_BIT_PLL_EN      0
`define AA_BIT_DEEMPH      4
`define AA_BIT_OUT_PRE     0
`define AA_BIT_PIN_TWO     5
`define AA_BIT_PIN_ZERO    3
`define AA_BIT_PIN_ONE     2
`define AA_BIT_BCLK_INV    5
`define AA_BIT_BCLK_MST    4
`define AA_BIT_FRAME_MST   0

// ********************************
// Timing
// ********************************
`define AA_CLK_PERIOD_NS   40
`define AA_RAMP_STEP_NS    1000

`endif

// ### hw/aa_vol_ramp.v
// Soft mute volume ramp for one channel.
// Assumes a mute request level from the same clock domain.
`timescale 1ns/1ps
module aa_vol_ramp #(
  parameter WIDTH       = 8,
  parameter STEP_CYCLES = 25
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire             mute_req,
  output reg  [WIDTH-1:0] gain,
  output reg              at_target
);

  localparam [WIDTH-1:0] FULL = {WIDTH{1'b1}};
  localparam integer     LAST_I = STEP_CYCLES - 1;
  localparam [15:0]      LAST   = LAST_I[15:0];

  reg [15:0] tick_cnt;
  wire       tick = (tick_cnt == LAST);

  // ********************************
  // Step timer and ramp
  // ********************************
  always @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt  <= 16'h0000;
      gain      <= {WIDTH{1'b1}};
      at_target <= 1'b1;
    end else begin
      tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
      if (tick) begin
        // One step per tick, no jumps, so no pop
        if (mute_req && gain != {WIDTH{1'b0}})
          gain <= gain - {{(WIDTH-1){1'b0}}, 1'b1};
        else if (!mute_req && gain != FULL)
          gain <= gain + {{(WIDTH-1){1'b0}}, 1'b1};
      end
      at_target <= mute_req ? (gain == {WIDTH{1'b0}}) : (gain == FULL);
    end
  end

endmodule

// ### hw/aa_ctrl_regs.v
// Page-zero control and status registers of the amplifier core.
// Assumes a decoded control-port register access on ref_clk and
// pins from outside the clock domain on the serial and general pins.
//
// Function
// - Mute bit 4 soft-ramps second channel
// - Mute bit 0 soft-ramps first channel
// - PLL bit 4 reads 0 locked, 1 not
// - Disabled PLL always reads not locked
// - PLL bit 0 enables internal PLL
// - PLL off selects external master clock
// - Filter bit 4 enables de-emphasis filter
// - De-emphasis coefficients default, software replaceable
// - Filter bit 0 picks serial output source
// - Direction bit 5 drives pin two
// - Direction bit 3 drives pin zero
// - Direction bit 2 drives pin one
// - Interface bit 5 picks bit clock edge
// - Interface bit 4 makes bit clock output
// - Master bit clock divides master clock
// - Interface bit 0 makes frame clock output
// - Master frame clock divides bit clock
`timescale 1ns/1ps
`include "aa_regs.vh"
module aa_ctrl_regs #(
  parameter COEF_W = 24,
  parameter COEF_N = 4,
  parameter COEF_DEFAULT0 = 24'h000100,
  parameter COEF_DEFAULT1 = 24'h000200,
  parameter COEF_DEFAULT2 = 24'h000300,
  parameter COEF_DEFAULT3 = 24'h000400
) (
  input  wire              ref_clk,
  input  wire              rst,
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata,
  input  wire [1:0]        coef_addr,
  input  wire [COEF_W-1:0] coef_wdata,
  input  wire              coef_wr,
  output reg  [COEF_W-1:0] coef_rdata,
  input  wire              pll_lock_raw,
  output reg               pll_enable,
  output reg               clk_src_ext,
  output wire [7:0]        vol_gain_a,
  output wire [7:0]        vol_gain_b,
  output wire              ramp_done_a,
  output wire              ramp_done_b,
  output reg               deemph_enable,
  input  wire              dsp_post_data,
  output reg               serial_audio_output,
  input  wire [2:0]        gpio_out_data,
  output reg  [2:0]        gpio_in_data,
  input  wire              general_pin_zero_i,
  output reg               general_pin_zero_o,
  output reg               general_pin_zero_oe,
  input  wire              general_pin_one_i,
  output reg               general_pin_one_o,
  output reg               general_pin_one_oe,
  input  wire              general_pin_two_i,
  output reg               general_pin_two_o,
  output reg               general_pin_two_oe,
  input  wire [7:0]        bclk_div,
  input  wire [9:0]        frame_div,
  input  wire              bclk_div_run,
  input  wire              frame_div_run,
  input  wire              bit_clock_i,
  output reg               bit_clock_o,
  output reg               bit_clock_oe,
  input  wire              frame_sync_clock_i,
  output reg               frame_sync_clock_o,
  output reg               frame_sync_clock_oe,
  input  wire              serial_audio_input,
  output reg               rx_strobe,
  output reg               rx_data,
  output reg               rx_frame
);

  localparam integer RAMP_CYCLES =
    (`AA_RAMP_STEP_NS + `AA_CLK_PERIOD_NS - 1) / `AA_CLK_PERIOD_NS;

  // ********************************
  // Helpers
  // ********************************
  function sample_edge;
    input prev;
    input cur;
    input inv;
    begin
      // Normal: data moves on falling, sample on rising
      sample_edge = inv ? (prev & ~cur) : (~prev & cur);
    end
  endfunction

  function launch_edge;
    input prev;
    input cur;
    input inv;
    begin
      launch_edge = inv ? (~prev & cur) : (prev & ~cur);
    end
  endfunction

  function [COEF_W-1:0] coef_default;
    input [1:0] idx;
    begin
      case (idx)
        2'h0:    coef_default = COEF_DEFAULT0;
        2'h1:    coef_default = COEF_DEFAULT1;
        2'h2:    coef_default = COEF_DEFAULT2;
        default: coef_default = COEF_DEFAULT3;
      endcase
    end
  endfunction

  // ********************************
  // Register storage
  // ********************************
  reg [7:0] mute_reg;
  reg [7:0] pll_reg;
  reg [7:0] filt_reg;
  reg [7:0] dir_reg;
  reg [7:0] serif_reg;
  reg       lock_s1;
  reg       lock_s2;
  wire      lock_flag_n;

  // Not locked whenever disabled
  assign lock_flag_n = ~(pll_reg[`AA_BIT_PLL_EN] & lock_s2);

  always @(posedge ref_clk) begin
    if (rst) begin
      mute_reg  <= `AA_RST_MUTE;
      pll_reg   <= `AA_RST_PLL;
      filt_reg  <= `AA_RST_FILT;
      dir_reg   <= `AA_RST_PIN_DIR;
      serif_reg <= `AA_RST_SER_IF;
    end else if (reg_wr) begin
      // Only defined bits are stored
      case (reg_addr)
        `AA_OFS_MUTE:    mute_reg  <= reg_wdata & `AA_WMASK_MUTE;
        `AA_OFS_PLL:     pll_reg   <= reg_wdata & `AA_WMASK_PLL;
        `AA_OFS_FILT:    filt_reg  <= reg_wdata & `AA_WMASK_FILT;
        `AA_OFS_PIN_DIR: dir_reg   <= reg_wdata & `AA_WMASK_PIN_DIR;
        `AA_OFS_SER_IF:  serif_reg <= reg_wdata & `AA_WMASK_SER_IF;
        default: ;
      endcase
    end
  end

  // ********************************
  // Read path
  // ********************************
  reg [7:0] next_rdata;

  always @* begin
    case (reg_addr)
      `AA_OFS_MUTE:    next_rdata = mute_reg;
      `AA_OFS_PLL:     next_rdata = pll_reg |
                         {3'h0, lock_flag_n, 4'h0};
      `AA_OFS_FILT:    next_rdata = filt_reg;
      `AA_OFS_PIN_DIR: next_rdata = dir_reg;
      `AA_OFS_SER_IF:  next_rdata = serif_reg;
      default:         next_rdata = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // ********************************
  // PLL control
  // ********************************
  always @(posedge ref_clk) begin
    if (rst) begin
      lock_s1     <= 1'b0;
      lock_s2     <= 1'b0;
      pll_enable  <= 1'b1;
      clk_src_ext <= 1'b0;
    end else begin
      lock_s1     <= pll_lock_raw;
      lock_s2     <= lock_s1;
      pll_enable  <= pll_reg[`AA_BIT_PLL_EN];
      clk_src_ext <= ~pll_reg[`AA_BIT_PLL_EN];
    end
  end

  // ********************************
  // Soft mute ramps
  // ********************************
  wire [7:0] gain_w [0:1];
  wire [1:0] done_w;
  wire [1:0] mute_req;

  assign mute_req[0] = mute_reg[`AA_BIT_MUTE_A];
  assign mute_req[1] = mute_reg[`AA_BIT_MUTE_B];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ramp
      aa_vol_ramp #(
        .WIDTH       (8),
        .STEP_CYCLES (RAMP_CYCLES)
      ) u_ramp (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .mute_req  (mute_req[ch]),
        .gain      (gain_w[ch]),
        .at_target (done_w[ch])
      );
    end
  endgenerate

  assign vol_gain_a  = gain_w[0];
  assign vol_gain_b  = gain_w[1];
  assign ramp_done_a = done_w[0];
  assign ramp_done_b = done_w[1];

  // ********************************
  // De-emphasis coefficient space
  // ********************************
  reg [COEF_W-1:0] coef_mem [0:COEF_N-1];
  integer k;

  always @(posedge ref_clk) begin
    if (rst) begin
      for (k = 0; k < COEF_N; k = k + 1)
        coef_mem[k] <= coef_default(k[1:0]);
      coef_rdata    <= {COEF_W{1'b0}};
      deemph_enable <= 1'b0;
    end else begin
      if (coef_wr)
        coef_mem[coef_addr] <= coef_wdata;
      coef_rdata    <= coef_mem[coef_addr];
      deemph_enable <= filt_reg[`AA_BIT_DEEMPH];
    end
  end

  // ********************************
  // Pin synchronisers
  // ********************************
  reg [2:0] gp_s1;
  reg [2:0] gp_s2;
  reg       bclk_s1;
  reg       bclk_s2;
  reg       frame_s1;
  reg       frame_s2;
  reg       serial_audio_input_s1;
  reg       serial_audio_input_s2;

  always @(posedge ref_clk) begin
    if (rst) begin
      gp_s1    <= 3'h0;
      gp_s2    <= 3'h0;
      bclk_s1  <= 1'b0;
      bclk_s2  <= 1'b0;
      frame_s1 <= 1'b0;
      frame_s2 <= 1'b0;
      serial_audio_input_s1  <= 1'b0;
      serial_audio_input_s2  <= 1'b0;
    end else begin
      gp_s1    <= {general_pin_two_i, general_pin_one_i,
                   general_pin_zero_i};
      gp_s2    <= gp_s1;
      bclk_s1  <= bit_clock_i;
      bclk_s2  <= bclk_s1;
      frame_s1 <= frame_sync_clock_i;
      frame_s2 <= frame_s1;
      serial_audio_input_s1  <= serial_audio_input;
      serial_audio_input_s2  <= serial_audio_input_s1;
    end
  end

  // ********************************
  // General pins and serial output
  // ********************************
  always @(posedge ref_clk) begin
    if (rst) begin
      general_pin_zero_o  <= 1'b0;
      general_pin_zero_oe <= 1'b0;
      general_pin_one_o   <= 1'b0;
      general_pin_one_oe  <= 1'b0;
      general_pin_two_o   <= 1'b0;
      general_pin_two_oe  <= 1'b0;
      gpio_in_data        <= 3'h0;
      serial_audio_output <= 1'b0;
    end else begin
      general_pin_zero_o  <= gpio_out_data[0];
      general_pin_zero_oe <= dir_reg[`AA_BIT_PIN_ZERO];
      general_pin_one_o   <= gpio_out_data[1];
      general_pin_one_oe  <= dir_reg[`AA_BIT_PIN_ONE];
      general_pin_two_o   <= gpio_out_data[2];
      general_pin_two_oe  <= dir_reg[`AA_BIT_PIN_TWO];
      gpio_in_data        <= gp_s2;
      // Pre-processing input or processed output
      serial_audio_output <= filt_reg[`AA_BIT_OUT_PRE] ?
                             serial_audio_input_s2 : dsp_post_data;
    end
  end

  // ********************************
  // Master clock generation
  // ********************************
  wire       bclk_inv   = serif_reg[`AA_BIT_BCLK_INV];
  wire       bclk_mst   = serif_reg[`AA_BIT_BCLK_MST];
  wire       frame_mst  = serif_reg[`AA_BIT_FRAME_MST];
  wire [6:0] bclk_half  = (bclk_div[7:1] == 7'h00) ? 7'h01 : bclk_div[7:1];
  wire [8:0] frame_half =
    (frame_div[9:1] == 9'h000) ? 9'h001 : frame_div[9:1];
  reg  [6:0] bclk_cnt;
  reg  [8:0] frame_cnt;
  reg        bclk_prev_int;

  always @(posedge ref_clk) begin
    if (rst) begin
      bclk_cnt           <= 7'h00;
      frame_cnt          <= 9'h000;
      bit_clock_o        <= 1'b0;
      bit_clock_oe       <= 1'b0;
      frame_sync_clock_o <= 1'b0;
      frame_sync_clock_oe <= 1'b0;
      bclk_prev_int      <= 1'b0;
    end else begin
      bit_clock_oe        <= bclk_mst;
      frame_sync_clock_oe <= frame_mst;
      bclk_prev_int       <= bit_clock_o;
      if (!bclk_div_run) begin
        bclk_cnt    <= 7'h00;
        bit_clock_o <= 1'b0;
      end else if (bclk_cnt == bclk_half - 7'h01) begin
        // Bit clock is master clock over bclk_div rounded down to even, at least 2
        bclk_cnt    <= 7'h00;
        bit_clock_o <= ~bit_clock_o;
      end else begin
        bclk_cnt <= bclk_cnt + 7'h01;
      end
      // Frame moves on the launch edge of the bit clock
      if (!frame_div_run || !bclk_div_run) begin
        frame_cnt          <= 9'h000;
        frame_sync_clock_o <= 1'b0;
      end else if (launch_edge(bclk_prev_int, bit_clock_o, bclk_inv)) begin
        if (frame_cnt == frame_half - 9'h001) begin
          frame_cnt          <= 9'h000;
          frame_sync_clock_o <= ~frame_sync_clock_o;
        end else begin
          frame_cnt <= frame_cnt + 9'h001;
        end
      end
    end
  end

  // ********************************
  // Serial receive sampling
  // ********************************
  // Master mode samples against own clocks; source follows them
  wire bclk_lvl  = bclk_mst ? bit_clock_o : bclk_s2;
  wire frame_lvl = frame_mst ? frame_sync_clock_o : frame_s2;
  reg  bclk_prev;

  always @(posedge ref_clk) begin
    if (rst) begin
      bclk_prev <= 1'b0;
      rx_strobe <= 1'b0;
      rx_data   <= 1'b0;
      rx_frame  <= 1'b0;
    end else begin
      bclk_prev <= bclk_lvl;
      rx_strobe <= sample_edge(bclk_prev, bclk_lvl, bclk_inv);
      if (sample_edge(bclk_prev, bclk_lvl, bclk_inv)) begin
        rx_data  <= serial_audio_input_s2;
        rx_frame <= frame_lvl;
      end
    end
  end

endmodule

// ### tb/aa_monitor.sv
// Assertion checker on the page-zero register block ports.
// Assumes a bind onto aa_ctrl_regs from the bench top.
`timescale 1ns/1ps
module aa_monitor (
  input wire       ref_clk,
  input wire       rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       pll_enable,
  input wire       clk_src_ext,
  input wire [7:0] vol_gain_a,
  input wire       deemph_enable,
  input wire       general_pin_zero_oe,
  input wire       general_pin_one_oe,
  input wire       general_pin_two_oe,
  input wire       bit_clock_oe
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire w_pll = reg_wr && reg_addr == 8'h04;
  wire w_flt = reg_wr && reg_addr == 8'h07;
  wire w_dir = reg_wr && reg_addr == 8'h08;
  wire w_ser = reg_wr && reg_addr == 8'h09;
  function automatic [7:0] rmask(input [7:0] a);
    case (a)
      8'h03, 8'h04, 8'h07: rmask = 8'h11;
      8'h08:               rmask = 8'h2c;
      8'h09:               rmask = 8'h31;
      default:             rmask = 8'h00;
    endcase
  endfunction
  property p_pll;
    w_pll |-> ##2 pll_enable == $past(reg_wdata[0], 2);
  endproperty
  a_pll: assert property (p_pll) else $error("pll enable");
  property p_src;
    clk_src_ext != pll_enable;
  endproperty
  a_src: assert property (p_src) else $error("clock source");
  property p_lock;
    reg_rd && reg_addr == 8'h04 && !pll_enable && !$past(reg_wr)
      |=> reg_rdata[4];
  endproperty
  a_lock: assert property (p_lock) else $error("lock flag");
  property p_rsv;
    reg_rd |=> (reg_rdata & ~rmask($past(reg_addr))) == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_dir;
    w_dir |-> ##2 {general_pin_two_oe, general_pin_zero_oe,
      general_pin_one_oe} == {$past(reg_wdata[5], 2),
      $past(reg_wdata[3], 2), $past(reg_wdata[2], 2)};
  endproperty
  a_dir: assert property (p_dir) else $error("oe");
  property p_deemph;
    w_flt |-> ##2 deemph_enable == $past(reg_wdata[4], 2);
  endproperty
  a_deemph: assert property (p_deemph) else $error("deemph");
  property p_bclk;
    w_ser |-> ##2 bit_clock_oe == $past(reg_wdata[4], 2);
  endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock dir");
  property p_ramp;
    $changed(vol_gain_a) |-> (vol_gain_a - $past(vol_gain_a) == 8'h01 ||
      $past(vol_gain_a) - vol_gain_a == 8'h01) ##1 $stable(vol_gain_a)[*8];
  endproperty
  a_ramp: assert property (p_ramp) else $error("gain step");
endmodule

// ### tb/aa_source.sv
// Serial audio source on the far side of the link.
// Assumes resolved clock pin levels from the bench.
`timescale 1ns/1ps
module aa_source (
  input wire ref_clk,
  input wire master,
  input wire inv,
  input wire bclk_pin,
  output reg bclk_drv,
  output reg fs_drv,
  output reg sdata
);
  // ****************
  // Frame sender
  // ****************
  reg     [15:0] tx_word = 16'h0000;
  integer        k;
  initial begin
    bclk_drv = 1'b0;
    fs_drv = 1'b0;
    sdata = 1'b0;
  end
  // Static data level set by the bench
  task put(input b);
    begin
      sdata = b;
    end
  endtask
  // Clock rests at its sample level between frames
  task park;
    begin
      bclk_drv = !inv;
      repeat (8) @(negedge ref_clk);
    end
  endtask
  // Data moves 2 cycles after the launch edge
  task send(input [15:0] w);
    begin
      for (k = 15; k >= 0; k = k - 1) begin
        bclk_drv = inv;
        repeat (2) @(negedge ref_clk);
        sdata = w[k];
        fs_drv = k > 7;
        repeat (4) @(negedge ref_clk);
        bclk_drv = !inv;
        repeat (6) @(negedge ref_clk);
      end
      bclk_drv = inv;
      repeat (2) @(negedge ref_clk);
      sdata = !sdata;
    end
  endtask
  // Follow the device clocks in master mode
  always @(bclk_pin)
    if (master && bclk_pin == inv) begin
      sdata <= tx_word[15];
      tx_word <= {tx_word[14:0], !tx_word[15]};
    end
endmodule

// ### tb/tb_top.sv
// Bench top for the page-zero register block.
// Assumes aa_ctrl_regs, aa_source and aa_monitor are compiled first.
`timescale 1ns/1ps
module tb_top;
  // ****************
  // Harness
  // ****************
  localparam [47:0] ADR = 48'h03_04_07_08_09_05;
  localparam [47:0] RST_V = 48'h00_01_00_00_00_00;
  localparam [47:0] SET_V = 48'h00_01_11_2c_31_00;
  localparam [47:0] CLR_V = 48'h00_10_00_00_00_00;
  localparam [23:0] DIR_W = 24'h20_08_04;
  localparam [8:0]  DIR_OE = 9'b100_001_010;
  localparam [23:0] CF_DEF = 24'h00a5a5;
  reg        ref_clk = 1'b0;
  reg        rst = 1'b1;
  reg  [7:0] reg_addr = 8'h00;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr = 1'b0;
  reg        reg_rd = 1'b0;
  reg        pll_lock_raw = 1'b1;
  reg        dsp_post_data = 1'b0;
  reg  [2:0] gpio_out_data = 3'b000;
  reg  [2:0] gp_drv = 3'b111;
  reg  [7:0] bclk_div = 8'h08;
  reg  [9:0] frame_div = 10'h004;
  reg        bclk_div_run = 1'b0;
  reg        frame_div_run = 1'b0;
  reg        inv = 1'b0;
  reg  [1:0] coef_addr = 2'h0;
  reg [23:0] coef_wdata = 24'h000000;
  reg        coef_wr = 1'b0;
  wire [23:0] coef_rdata;
  reg  [1:0] pb;
  reg [15:0] rx_bits, rx_fr;
  integer    num_errors = 0, checked = 0, n_rx = 0, i, n, nb, nf;
  wire [7:0] reg_rdata, vol_gain_a, vol_gain_b;
  wire [2:0] gpio_in_data;
  wire       pll_enable, clk_src_ext, ramp_done_a, ramp_done_b;
  wire       deemph_enable, serial_audio_output, rx_strobe, rx_data;
  wire       general_pin_zero_o, general_pin_zero_oe, general_pin_one_o;
  wire       general_pin_one_oe, general_pin_two_o, general_pin_two_oe;
  wire       bit_clock_o, bit_clock_oe, frame_sync_clock_o, rx_frame;
  wire       frame_sync_clock_oe, serial_audio_input, src_bclk, src_fs;
  wire       general_pin_zero_i =
    general_pin_zero_oe ? general_pin_zero_o : gp_drv[0];
  wire       general_pin_one_i =
    general_pin_one_oe ? general_pin_one_o : gp_drv[1];
  wire       general_pin_two_i =
    general_pin_two_oe ? general_pin_two_o : gp_drv[2];
  wire       bit_clock_i = bit_clock_oe ? bit_clock_o : src_bclk;
  wire       frame_sync_clock_i =
    frame_sync_clock_oe ? frame_sync_clock_o : src_fs;
  wire [2:0] pin_oe =
    {general_pin_two_oe, general_pin_one_oe, general_pin_zero_oe};
  wire [3:0] clk_st =
    {pll_enable, clk_src_ext, deemph_enable, bit_clock_oe};
  always #20 ref_clk = ~ref_clk;
  aa_ctrl_regs #(.COEF_DEFAULT1(CF_DEF)) aa_ctrl_regs_i (.ref_clk, .rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .coef_addr,
    .coef_wdata, .coef_wr, .coef_rdata,
    .pll_lock_raw, .pll_enable, .clk_src_ext, .vol_gain_a, .vol_gain_b,
    .ramp_done_a, .ramp_done_b, .deemph_enable, .dsp_post_data,
    .serial_audio_output, .gpio_out_data, .gpio_in_data,
    .general_pin_zero_i, .general_pin_zero_o, .general_pin_zero_oe,
    .general_pin_one_i, .general_pin_one_o, .general_pin_one_oe,
    .general_pin_two_i, .general_pin_two_o, .general_pin_two_oe,
    .bclk_div, .frame_div, .bclk_div_run, .frame_div_run, .bit_clock_i,
    .bit_clock_o, .bit_clock_oe, .frame_sync_clock_i, .frame_sync_clock_o,
    .frame_sync_clock_oe, .serial_audio_input, .rx_strobe, .rx_data,
    .rx_frame);
  aa_source aa_source_i (.ref_clk(ref_clk), .master(bit_clock_oe),
    .inv(inv), .bclk_pin(bit_clock_i), .bclk_drv(src_bclk),
    .fs_drv(src_fs), .sdata(serial_audio_input));
  always @(posedge ref_clk)
    if (rx_strobe) begin
      rx_bits <= {rx_bits[14:0], rx_data};
      rx_fr <= {rx_fr[14:0], rx_frame};
      n_rx <= n_rx + 1;
    end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      if (num_errors == 0 && checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, e);
    end
  endtask
  task ramp_wait;
    begin
      n = 0;
      repeat (4) @(negedge ref_clk);
      while (!(ramp_done_a && ramp_done_b) && n < 9000) begin
        @(negedge ref_clk);
        n = n + 1;
      end
      if (n == 9000) begin
        chk(0, 1);
        end_of_test;
      end
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    bclk_div_run = 1'b1;
    frame_div_run = 1'b1;
    for (i = 0; i < 6; i = i + 1)
      rd(ADR[8*i +: 8], RST_V[8*i +: 8]);
    for (i = 0; i < 5; i = i + 1)
      wr(ADR[8*i +: 8], 8'hff);
    for (i = 0; i < 6; i = i + 1)
      rd(ADR[8*i +: 8], SET_V[8*i +: 8]);
    chk(clk_st, 4'hb);
    chk(frame_sync_clock_oe, 1);
    nb = 0;
    nf = 0;
    repeat (256) begin
      pb = {bit_clock_o, frame_sync_clock_o};
      @(negedge ref_clk);
      nb = nb + (bit_clock_o != pb[1]);
      nf = nf + (frame_sync_clock_o != pb[0]);
    end
    chk(nb, 64);
    chk(nf, 16);
    for (i = 0; i < 5; i = i + 1)
      wr(ADR[8*i +: 8], 8'h00);
    for (i = 0; i < 6; i = i + 1)
      rd(ADR[8*i +: 8], CLR_V[8*i +: 8]);
    chk(clk_st, 4'h4);
    wr(8'h04, 8'h01);
    pll_lock_raw = 1'b0;
    repeat (4) @(negedge ref_clk);
    rd(8'h04, 8'h11);
    pll_lock_raw = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(8'h04, 8'h01);
    wr(8'h03, 8'h01);
    ramp_wait;
    chk(n >= 6300 && n <= 6420, 1);
    chk({vol_gain_a, vol_gain_b}, 16'h00ff);
    wr(8'h03, 8'h10);
    ramp_wait;
    chk({vol_gain_a, vol_gain_b}, 16'hff00);
    wr(8'h03, 8'h00);
    ramp_wait;
    chk(vol_gain_b, 8'hff);
    for (i = 0; i < 4; i = i + 1) begin
      if (i == 2)
        wr(8'h07, 8'h01);
      dsp_post_data = i[0];
      aa_source_i.put(!i[0]);
      repeat (6) @(negedge ref_clk);
      chk(serial_audio_output, i[0] ^ (i >= 2));
    end
    wr(8'h07, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk(serial_audio_output, 1);
    coef_addr = 2'h1;
    repeat (2) @(negedge ref_clk);
    chk(coef_rdata, CF_DEF);
    coef_wdata = 24'h123456;
    coef_wr = 1'b1;
    @(negedge ref_clk);
    coef_wr = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(coef_rdata, 24'h123456);
    for (i = 0; i < 3; i = i + 1) begin
      wr(8'h08, DIR_W[8*i +: 8]);
      repeat (5) @(negedge ref_clk);
      chk(pin_oe, DIR_OE[3*i +: 3]);
      chk(gpio_in_data, DIR_OE[3*i +: 3] ^ 3'b111);
    end
    for (i = 0; i < 2; i = i + 1) begin
      inv = i[0];
      wr(8'h09, i[0] ? 8'h20 : 8'h00);
      aa_source_i.park;
      nf = n_rx;
      aa_source_i.send(16'ha5c3 ^ {16{i[0]}});
      repeat (8) @(negedge ref_clk);
      chk(n_rx - nf, 16);
      chk({rx_bits, rx_fr}, {16'ha5c3 ^ {16{i[0]}}, 16'hff00});
    end
    end_of_test;
  end
endmodule
bind aa_ctrl_regs aa_monitor aa_monitor_i (.ref_clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pll_enable, .clk_src_ext,
  .vol_gain_a, .deemph_enable, .general_pin_zero_oe, .general_pin_one_oe,
  .general_pin_two_oe, .bit_clock_oe);
